// File: design/pdm_router_pkg.sv
/*
 * Shared constants and carrier types for the PDM output channel router.
 * Assumes a 100 MHz core clock and an APB master with 32-bit data.
 */
package pdm_router_pkg;

	// Sample width of one processed audio channel.
	localparam int SAMPLE_W = 16;

	// APB register byte offsets.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_GAIN0  = 8'h04;
	localparam logic [7:0] OFS_GAIN1  = 8'h08;
	localparam logic [7:0] OFS_ATTEN  = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Control register field positions.
	localparam int CTRL_LSEL   = 0;
	localparam int CTRL_RSEL   = 1;
	localparam int CTRL_LMUTE  = 2;
	localparam int CTRL_RMUTE  = 3;
	localparam int CTRL_DIFF   = 4;
	localparam int CTRL_DRVEN  = 5;
	localparam int CTRL_EXTCLK = 6;
	localparam int CTRL_PDMEN  = 7;

	// Gain register fields: coarse steps of 6 dB in [2:0], fine gain in [15:8].
	localparam int GAIN_COARSE_LSB = 0;
	localparam int GAIN_FINE_LSB   = 8;

	// Attenuator register fields.
	localparam int ATTEN0_LSB = 0;
	localparam int ATTEN1_LSB = 8;

	// Values after reset.
	localparam logic [2:0] COARSE_RESET = 3'h0;
	localparam logic [7:0] FINE_RESET   = 8'h80;
	localparam logic [3:0] ATTEN_RESET  = 4'h0;

	// Timing of the swap input debounce.
	localparam longint CLK_FREQ_HZ  = 100_000_000;
	localparam longint SWAP_HOLD_MS = 200;
	localparam longint SWAP_HOLD_CYCLES = (SWAP_HOLD_MS * CLK_FREQ_HZ) / 1000;

	// Cycles the pin synchronisers need before the boot strap is valid.
	localparam logic [1:0] BOOT_WAIT_CYCLES = 2'h3;

	// One frame of processed audio: both channels together.
	typedef struct packed {
		logic signed [SAMPLE_W-1:0] ch1;
		logic signed [SAMPLE_W-1:0] ch0;
	} sample_pair_s;

	// Gain setting of one channel.
	typedef struct packed {
		logic [7:0] fine;
		logic [2:0] coarse;
	} gain_s;

endpackage

// File: design/pdm_output_channel_router.sv
/*
 * PDM output channel router: sample FIFO, per-channel gain, sigma-delta
 * modulators, slot routing and muting onto the digital microphone line,
 * analog and driver bitstreams, APB register file.
 * Assumes the external codec drives external_clock_in, which is sampled
 * asynchronously, and that the processed samples arrive on core_clk.
 */
// The APB register port and the register addresses were left to the implementer.
// Notes on behaviour
// R1 - Always two output channels, zero and one.
// R2 - Per-channel coarse gain in 6 dB steps.
// R3 - Per-channel fine gain applied with coarse.
// R4 - Sigma-delta modulator makes each channel's bitstream.
// R5 - PDM mode drives bitstream onto data pin.
// R6 - Output bits follow the external PDM clock.
// R7 - Left and right slots pick channel.
// R8 - Muted slot drives constant zero.
// R9 - Stereo strap: channel 0 left, 1 right.
// R10 - Mono strap: channel 0 on both slots.
// R11 - Mono after swap: channel 1 both slots.
// R12 - Differential mode: channel 1 is inverted 0.
// R13 - Host sets both attenuators equal in differential.
// R14 - Attenuators reset to 0 dB, stay writable.
// R15 - Driver off by default, same mode select.
// R16 - Synchronised output runs from external clock.
// R17 - Swap toggles after 200 ms low, debounced.
// R18 - Left on rising edge, right on falling.

module pdm_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wrPtr_ff;
	logic [AW-1:0]    rdPtr_ff;
	logic [AW:0]      count_ff;
	logic [AW:0]      nxt_count;
	logic             notFull_ff;
	logic             push;
	logic             pop;

	// Ready is a flop of its own, updated with the count, so it leaves the block clean.
	assign push      = inValid && inReady;
	assign pop       = outValid && outReady;
	assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
	assign inReady   = notFull_ff;
	assign outValid = (count_ff != '0);
	assign outData  = mem_ff[rdPtr_ff];

	// Storage is written only on an accepted push, so no reset is needed.
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wrPtr_ff] <= inData;
		end
	end

	// Pointers wrap at DEPTH; the count keeps full and empty honest.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
			notFull_ff <= 1'b1;
		end else begin
			if (push) begin
				wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
			end
			if (pop) begin
				rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
			end
			count_ff   <= nxt_count;
			notFull_ff <= (nxt_count != (AW+1)'(DEPTH));
		end
	end
endmodule

module pdm_output_channel_router
	import pdm_router_pkg::*;
#(
	parameter longint SWAP_CYCLES = SWAP_HOLD_CYCLES,
	parameter int     OSR         = 64,
	parameter int     FIFO_DEPTH  = 8
) (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire sample_pair_s       sampleIn,
	input  wire logic               sampleValid,
	output logic                    sampleReady,
	input  wire logic               external_clock_in,
	input  wire logic               mono_stereo_select,
	input  wire logic               channel_swap_in,
	output logic                    pdm_data_out,
	output logic                    analog_out_zero,
	output logic                    analog_out_one,
	output logic                    driverOut0,
	output logic                    driverOut1,
	output logic [3:0]              attenZero,
	output logic [3:0]              attenOne,
	output logic                    clkSrcExternal
);
	localparam int OSR_W = $clog2(OSR);
	localparam int SW_W  = $clog2(SWAP_CYCLES + 1);
	localparam int ACC_W = SAMPLE_W + 3;

	// Pin synchronisers: clock, strap, swap.
	logic [2:0] pinS1_ff;
	logic [2:0] pinS2_ff;
	logic [2:0] pinS3_ff;
	logic [2:0] pinLvl_ff;
	logic       clkLvl;
	logic       monoLvl;
	logic       swapLvl;
	logic       clkPrev_ff;
	logic       riseTick;
	logic       fallTick;

	// Registers.
	logic [7:0] ctrl_ff;
	gain_s      gain_ff [2];
	logic [3:0] atten0_ff;
	logic [3:0] atten1_ff;
	logic [1:0] bootCnt_ff;
	logic       bootDone_ff;
	logic       bootLoad;
	logic       monoStrap_ff;

	// Swap debounce.
	logic [SW_W-1:0] swapCnt_ff;
	logic            swapFired_ff;
	logic            swapState_ff;

	// Datapath.
	sample_pair_s               fifoOut;
	logic                       fifoValid;
	logic                       fifoPop;
	logic [OSR_W-1:0]           osrCnt_ff;
	logic signed [SAMPLE_W-1:0] chanIn_ff [2];
	logic signed [SAMPLE_W-1:0] gained [2];
	logic signed [ACC_W-1:0]    acc_ff [2];
	logic [1:0]                 bit_ff;
	logic                       effSelL;
	logic                       effSelR;
	logic                       apbAccess;

	// Three flip-flops per pin; a level counts once the second and third agree.
	// They run through reset, so the strap has settled before the boot count reads it.
	always_ff @(posedge core_clk) begin
		pinS1_ff <= {channel_swap_in, mono_stereo_select, external_clock_in};
		pinS2_ff <= pinS1_ff;
		pinS3_ff <= pinS2_ff;
		for (int i = 0; i < 3; i++) begin
			if (pinS2_ff[i] == pinS3_ff[i]) begin
				pinLvl_ff[i] <= pinS2_ff[i];
			end
		end
	end
	assign clkLvl  = pinLvl_ff[0];
	assign monoLvl = pinLvl_ff[1];
	assign swapLvl = pinLvl_ff[2];

	// Edges of the incoming PDM clock pace all output bits. [R6]
	// The previous level tracks the pin through reset, so no false edge follows it.
	always_ff @(posedge core_clk) begin
		clkPrev_ff <= clkLvl;
	end
	assign riseTick = clkLvl && !clkPrev_ff;
	assign fallTick = !clkLvl && clkPrev_ff;

	// The strap is read once, after the synchronisers have settled past reset.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bootCnt_ff   <= 2'h0;
			bootDone_ff  <= 1'b0;
			monoStrap_ff <= 1'b0;
		end else if (!bootDone_ff) begin
			bootCnt_ff <= bootCnt_ff + 2'h1;
			if (bootLoad) begin
				bootDone_ff  <= 1'b1;
				monoStrap_ff <= monoLvl;
			end
		end
	end
	assign bootLoad = !bootDone_ff && (bootCnt_ff == BOOT_WAIT_CYCLES);

	// Swap debounce: one toggle per low period that lasts the full hold time.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			swapCnt_ff   <= '0;
			swapFired_ff <= 1'b0;
			swapState_ff <= 1'b0;
		end else if (swapLvl || !bootDone_ff) begin
			swapCnt_ff   <= '0;
			swapFired_ff <= 1'b0;
		end else if (!swapFired_ff) begin
			if (swapCnt_ff == SW_W'(SWAP_CYCLES - 1)) begin
				swapFired_ff <= 1'b1;
				swapState_ff <= !swapState_ff; // [R17]
			end else begin
				swapCnt_ff <= swapCnt_ff + 1'b1;
			end
		end
	end

	assign apbAccess = psel && penable && pready;

	// Control register: boot preset of the slots, then software writes.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_ff <= 8'h00; // Driver off by default. [R15]
		end else if (bootLoad) begin
			ctrl_ff[CTRL_LSEL] <= 1'b0; // [R9] [R10]
			ctrl_ff[CTRL_RSEL] <= !monoLvl; // [R9] [R10]
			ctrl_ff[CTRL_PDMEN] <= 1'b1;
		end else if (apbAccess && pwrite && paddr == OFS_CTRL) begin
			ctrl_ff <= pwdata[7:0];
		end
	end

	// Gain and attenuator registers.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int c = 0; c < 2; c++) begin
				gain_ff[c] <= '{fine: FINE_RESET, coarse: COARSE_RESET};
			end
			atten0_ff <= ATTEN_RESET; // [R14]
			atten1_ff <= ATTEN_RESET; // [R14]
		end else if (apbAccess && pwrite) begin
			unique case (paddr)
				OFS_GAIN0: gain_ff[0] <= {pwdata[GAIN_FINE_LSB+:8], pwdata[GAIN_COARSE_LSB+:3]};
				OFS_GAIN1: gain_ff[1] <= {pwdata[GAIN_FINE_LSB+:8], pwdata[GAIN_COARSE_LSB+:3]};
				OFS_ATTEN: begin
					atten0_ff <= pwdata[ATTEN0_LSB+:4]; // [R14]
					atten1_ff <= pwdata[ATTEN1_LSB+:4];
				end
				default: ;
			endcase
		end
	end

	// APB slave: one wait state, then pready with data; unmapped gives pslverr.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && penable && !pready) begin
				unique case (paddr)
					OFS_CTRL:   prdata <= {24'h0, ctrl_ff};
					OFS_GAIN0:  prdata <= {16'h0, gain_ff[0].fine, 5'h0, gain_ff[0].coarse};
					OFS_GAIN1:  prdata <= {16'h0, gain_ff[1].fine, 5'h0, gain_ff[1].coarse};
					OFS_ATTEN:  prdata <= {20'h0, atten1_ff, 4'h0, atten0_ff};
					OFS_STATUS: prdata <= {28'h0, clkSrcExternal, bootDone_ff,
						monoStrap_ff, swapState_ff};
					default:    pslverr <= 1'b1;
				endcase
			end
		end
	end

	// FIFO between the sample source and the modulators.
	pdm_fifo #(
		.WIDTH ($bits(sample_pair_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.inData   (sampleIn),
		.inValid  (sampleValid),
		.inReady  (sampleReady),
		.outData  (fifoOut),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	// One sample pair feeds OSR modulator steps; the FIFO stalls the source.
	assign fifoPop = riseTick && (osrCnt_ff == '0) && fifoValid;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			osrCnt_ff <= '0;
			chanIn_ff[0] <= '0;
			chanIn_ff[1] <= '0;
		end else begin
			if (riseTick) begin
				osrCnt_ff <= (osrCnt_ff == OSR_W'(OSR - 1)) ? '0 : osrCnt_ff + 1'b1;
			end
			if (fifoPop) begin
				chanIn_ff[0] <= fifoOut.ch0; // [R1]
				// Differential mode carries channel 0 inverted on channel 1.
				chanIn_ff[1] <= ctrl_ff[CTRL_DIFF] ? -fifoOut.ch0 : fifoOut.ch1; // [R12]
			end
		end
	end

	// Fine gain is Q1.7 (0x80 is unity); coarse shifts down 6 dB per step.
	function automatic logic signed [SAMPLE_W-1:0] apply_gain(
		input logic signed [SAMPLE_W-1:0] x,
		input gain_s g
	);
		logic signed [SAMPLE_W+9:0] prod;
		prod = (SAMPLE_W+10)'(x) * (SAMPLE_W+10)'($signed({1'b0, g.fine})); // [R3]
		prod = prod >>> 7;
		prod = prod >>> g.coarse; // [R2]
		if (prod > (SAMPLE_W+10)'(32767)) begin
			return SAMPLE_W'(32767);
		end
		if (prod < -(SAMPLE_W+10)'(32768)) begin
			return SAMPLE_W'(-32768);
		end
		return prod[SAMPLE_W-1:0];
	endfunction

	assign gained[0] = apply_gain(chanIn_ff[0], gain_ff[0]);
	assign gained[1] = apply_gain(chanIn_ff[1], gain_ff[1]);

	// First-order sigma-delta per channel, stepped on each rising clock edge.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			acc_ff[0] <= '0;
			acc_ff[1] <= '0;
			bit_ff    <= 2'h0;
		end else if (riseTick) begin
			for (int c = 0; c < 2; c++) begin
				logic signed [ACC_W-1:0] nxt_acc;
				nxt_acc = acc_ff[c] + ACC_W'(gained[c])
					- (bit_ff[c] ? ACC_W'(32767) : -ACC_W'(32768)); // [R4]
				acc_ff[c] <= nxt_acc;
				bit_ff[c] <= !nxt_acc[ACC_W-1]; // [R4]
			end
		end
	end

	// The swap toggles which channel each slot takes.
	assign effSelL = ctrl_ff[CTRL_LSEL] ^ swapState_ff; // [R7] [R11]
	assign effSelR = ctrl_ff[CTRL_RSEL] ^ swapState_ff; // [R7] [R11]

	// Left slot on the rising edge, right on the falling edge; mute forces zero.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pdm_data_out <= 1'b0;
		end else if (!ctrl_ff[CTRL_PDMEN]) begin
			pdm_data_out <= 1'b0;
		end else if (riseTick) begin
			pdm_data_out <= !ctrl_ff[CTRL_LMUTE] && bit_ff[effSelL]; // [R5] [R8] [R18]
		end else if (fallTick) begin
			pdm_data_out <= !ctrl_ff[CTRL_RMUTE] && bit_ff[effSelR]; // [R5] [R8] [R18]
		end
	end

	// Analog and driver bitstreams share the stereo or differential choice.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			analog_out_zero <= 1'b0;
			analog_out_one  <= 1'b0;
			driverOut0      <= 1'b0;
			driverOut1      <= 1'b0;
			attenZero       <= ATTEN_RESET;
			attenOne        <= ATTEN_RESET;
			clkSrcExternal  <= 1'b0;
		end else begin
			analog_out_zero <= bit_ff[0];
			analog_out_one  <= bit_ff[1];
			driverOut0      <= ctrl_ff[CTRL_DRVEN] && bit_ff[0]; // [R15]
			driverOut1      <= ctrl_ff[CTRL_DRVEN] && bit_ff[1]; // [R15]
			attenZero       <= atten0_ff;
			attenOne        <= atten1_ff;
			// The RC oscillator cannot track a codec clock.
			clkSrcExternal  <= ctrl_ff[CTRL_EXTCLK] || ctrl_ff[CTRL_PDMEN]; // [R16]
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_left_mute: assert property (ctrl_ff[CTRL_PDMEN] && ctrl_ff[CTRL_LMUTE] && riseTick // [R8]
		|=> !pdm_data_out) else $error("Muted left slot drove a one.");
	a_right_slot: assert property (ctrl_ff[CTRL_PDMEN] && fallTick && !riseTick // [R18]
		|=> pdm_data_out == (!$past(ctrl_ff[CTRL_RMUTE]) && $past(bit_ff[effSelR])))
		else $error("Right slot bit wrong on falling edge.");
	a_stereo_boot: assert property (bootLoad && !monoLvl // [R9]
		|=> !ctrl_ff[CTRL_LSEL] && ctrl_ff[CTRL_RSEL]) else $error("Stereo preset wrong.");
	a_mono_boot: assert property (bootLoad && monoLvl // [R10]
		|=> !ctrl_ff[CTRL_LSEL] && !ctrl_ff[CTRL_RSEL]) else $error("Mono preset wrong.");
	a_swap_select: assert property (bootDone_ff && monoStrap_ff && swapState_ff // [R11]
		&& !ctrl_ff[CTRL_LSEL] && !ctrl_ff[CTRL_RSEL] |-> effSelL && effSelR)
		else $error("Swapped mono does not select channel 1.");
	a_diff_invert: assert property (fifoPop && ctrl_ff[CTRL_DIFF] // [R12]
		|=> chanIn_ff[1] == -chanIn_ff[0]) else $error("Differential channel not inverted.");
	a_driver_off: assert property (!ctrl_ff[CTRL_DRVEN] // [R15]
		|=> !driverOut0 && !driverOut1) else $error("Disabled driver toggled.");
	a_ext_clock: assert property (ctrl_ff[CTRL_PDMEN] // [R16]
		|=> clkSrcExternal) else $error("PDM mode not on external clock.");
	a_swap_hold: assert property ($changed(swapState_ff) // [R17]
		|-> $past(swapCnt_ff) == SW_W'(SWAP_CYCLES - 1) && !$past(swapLvl))
		else $error("Swap toggled before hold time.");
	a_mod_step: assert property (!riseTick ##1 !riseTick // [R6]
		|-> $stable(bit_ff)) else $error("Modulator stepped without clock edge.");
endmodule

// File: testbench/pdm_codec_model.sv
/*
 * Codec-side model: makes the PDM bit clock and counts the ones it samples.
 * Assumes the router shows the left bit after a rising edge, right after a fall.
 */
module pdm_codec_model (
	input  wire logic run,
	input  wire logic pdm_data_out,
	output logic      external_clock_in,
	output int        leftOnes,
	output int        rightOnes,
	output int        frames
);
	timeunit 1ns;
	timeprecision 100ps;

	// The clock stands low until run rises; each half period is 80 ns.
	// A 2 ns offset keeps every clock change and sample clear of a core clock edge.
	initial begin
		external_clock_in = 1'b0;
		leftOnes = 0;
		rightOnes = 0;
		frames = 0;
		wait (run);
		#2;
		forever begin
			external_clock_in = 1'b1;
			#80;
			leftOnes = leftOnes + int'(pdm_data_out); // Sampled late, just before the fall.
			external_clock_in = 1'b0;
			#80;
			rightOnes = rightOnes + int'(pdm_data_out);
			frames = frames + 1;
		end
	end
endmodule

// File: testbench/pdm_output_channel_router_tb_top.sv
/*
 * Self-checking bench for the PDM router: APB tasks and slot density checks.
 * Assumes the codec model on the link and short swap and OSR parameters.
 */
module pdm_output_channel_router_tb_top;
	import pdm_router_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic         core_clk, rst_n, psel, penable, pwrite, run;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic         pready, pslverr, er, sampleValid, sampleReady;
	sample_pair_s sampleIn;
	logic         external_clock_in, mono_stereo_select, channel_swap_in;
	logic         pdm_data_out, analog_out_zero, analog_out_one;
	logic         driverOut0, driverOut1, clkSrcExternal;
	logic [3:0]   attenZero, attenOne;
	int           errors, comparisons, leftOnes, rightOnes, frames;
	int           l, r, n, a0, a1, d0, d1;

	// Short swap hold and oversampling keep the run brief.
	pdm_output_channel_router #(.SWAP_CYCLES(50), .OSR(4), .FIFO_DEPTH(8)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sampleIn(sampleIn),
		.sampleValid(sampleValid), .sampleReady(sampleReady),
		.external_clock_in(external_clock_in), .mono_stereo_select(mono_stereo_select),
		.channel_swap_in(channel_swap_in), .pdm_data_out(pdm_data_out),
		.analog_out_zero(analog_out_zero), .analog_out_one(analog_out_one),
		.driverOut0(driverOut0), .driverOut1(driverOut1), .attenZero(attenZero),
		.attenOne(attenOne), .clkSrcExternal(clkSrcExternal));

	pdm_codec_model u_codec (.run(run), .pdm_data_out(pdm_data_out),
		.external_clock_in(external_clock_in), .leftOnes(leftOnes),
		.rightOnes(rightOnes), .frames(frames));

	// Core clock, 100 MHz.
	always #5 core_clk = ~core_clk;

	task automatic tally_and_finish;
		if (errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			errors++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask

	// Bounded wait for k link frames; a stalled link counts as a mismatch.
	task automatic wait_frames(input int k);
		int f0, i;
		f0 = frames;
		for (i = 0; i < k * 40 && frames < f0 + k; i++)
			@(posedge core_clk);
		if (frames < f0 + k) begin
			errors++;
			tally_and_finish();
		end
	endtask

	// Density class: 0 mostly zero, 1 near half, 2 mostly one, 3 otherwise.
	function automatic int cls(input int ones, input int tot);
		if (ones * 8 > tot * 7)
			return 2;
		if (ones * 8 < tot)
			return 0;
		if (ones * 8 >= tot * 3 && ones * 8 <= tot * 5)
			return 1;
		return 3;
	endfunction

	// Settle past the FIFO contents, then count 64 frames on each slot.
	task automatic slots(input int el, input int ex);
		wait_frames(48);
		l = leftOnes;
		r = rightOnes;
		wait_frames(64);
		l = leftOnes - l;
		r = rightOnes - r;
		chk("left slot", el, cls(l, 64));
		chk("right slot", ex, cls(r, 64));
	endtask

	task automatic acount;
		repeat (800) @(posedge core_clk);
		{a0, a1, d0, d1} = '0;
		repeat (1600) begin
			@(posedge core_clk);
			a0 += int'(analog_out_zero);
			a1 += int'(analog_out_one);
			d0 += int'(driverOut0);
			d1 += int'(driverOut1);
		end
	endtask

	// Main sequence: channel 0 full positive, channel 1 full negative.
	initial begin
		core_clk = 1'b0;
		{rst_n, psel, penable, pwrite, paddr, pwdata, sampleValid, run} = '0;
		sampleIn = {16'h8001, 16'h7FFF};
		mono_stereo_select = 1'b0;
		channel_swap_in = 1'b1;
		errors = 0;
		comparisons = 0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		sampleValid <= 1'b1;
		n = 0;
		repeat (20) begin
			@(posedge core_clk);
			n += int'(sampleReady === 1'b1);
		end
		chk("fifo pushes", 8, n);
		chk("fifo ready", 0, sampleReady);
		rdchk(OFS_CTRL, 32'h82, "ctrl");
		rdchk(OFS_GAIN0, 32'h8000, "gain0");
		rdchk(OFS_GAIN1, 32'h8000, "gain1");
		rdchk(OFS_ATTEN, 32'h0, "atten");
		rdchk(OFS_STATUS, 32'hC, "status");
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 1, er);
		apb(1'b1, OFS_CTRL, 32'h02);
		@(posedge core_clk);
		chk("clock source off", 0, clkSrcExternal);
		apb(1'b1, OFS_CTRL, 32'h42);
		@(posedge core_clk);
		chk("clock source ext", 1, clkSrcExternal);
		apb(1'b1, OFS_CTRL, 32'hC2);
		chk("clock source", 1, clkSrcExternal);
		apb(1'b1, OFS_ATTEN, 32'h0505); // Equal settings for both paths.
		rdchk(OFS_ATTEN, 32'h0505, "atten rw");
		chk("atten0 pin", 5, attenZero);
		chk("atten1 pin", 5, attenOne);
		run <= 1'b1;
		slots(2, 0);
		apb(1'b1, OFS_CTRL, 32'hC1);
		slots(0, 2);
		apb(1'b1, OFS_CTRL, 32'hC6);
		slots(0, 0);
		chk("muted left", 0, l);
		apb(1'b1, OFS_CTRL, 32'hCA);
		slots(2, 0);
		chk("muted right", 0, r);
		apb(1'b1, OFS_CTRL, 32'hC2);
		apb(1'b1, OFS_GAIN0, 32'h0);
		slots(1, 0);
		apb(1'b1, OFS_GAIN0, 32'h8007);
		slots(1, 0);
		apb(1'b1, OFS_GAIN0, 32'h8000);
		apb(1'b1, OFS_GAIN1, 32'h0);
		slots(2, 1);
		apb(1'b1, OFS_GAIN1, 32'h8000);
		sampleIn <= {16'h7FFF, 16'h7FFF};
		acount();
		chk("driver0 off", 0, d0);
		chk("driver1 off", 0, d1);
		chk("analog one", 2, cls(a1, 1600));
		apb(1'b1, OFS_CTRL, 32'hF2);
		acount();
		chk("analog zero", 2, cls(a0, 1600));
		chk("analog diff", 0, cls(a1, 1600));
		chk("driver0 on", 2, cls(d0, 1600));
		chk("driver1 diff", 0, cls(d1, 1600));
		sampleIn <= {16'h8001, 16'h7FFF};
		mono_stereo_select <= 1'b1;
		rst_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		rdchk(OFS_CTRL, 32'h80, "mono ctrl");
		rdchk(OFS_ATTEN, 32'h0, "atten again");
		apb(1'b1, OFS_CTRL, 32'hC0);
		slots(2, 2);
		channel_swap_in <= 1'b0; // Held low past the debounce count.
		repeat (80) @(posedge core_clk);
		channel_swap_in <= 1'b1;
		slots(0, 0);
		rdchk(OFS_STATUS, 32'hF, "status swapped");
		tally_and_finish();
	end

	// A hang is cut short and counted as a mismatch.
	initial begin
		repeat (100000) @(posedge core_clk);
		errors++;
		tally_and_finish();
	end
endmodule
